// ---- verilog/tmrb_params.svh ----
// Register offsets, field positions, reset values and counts of the timer
`ifndef TMRB_PARAMS_SVH
`define TMRB_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------------
`define TMRB_ADDR_W 5
`define TMRB_OFS_CTRL 5'h00
`define TMRB_OFS_MODE 5'h04
`define TMRB_OFS_INTEN 5'h08
`define TMRB_OFS_FLAGS 5'h0C
`define TMRB_OFS_STATUS 5'h10
`define TMRB_OFS_DEBUG 5'h14
`define TMRB_OFS_COUNT 5'h18
`define TMRB_OFS_CMP 5'h1C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TMRB_CTRL_ENABLE 0
`define TMRB_CTRL_PRESCALE_SELECT_LO 1
`define TMRB_CTRL_PRESCALE_SELECT_HI 2
`define TMRB_CTRL_STDBY 6
`define TMRB_MODE_LO 0
`define TMRB_MODE_HI 2
`define TMRB_MODE_EDGE 4
`define TMRB_MODE_FILT 5
`define TMRB_MODE_EVEN 6
`define TMRB_INTEN_CAPT 0
`define TMRB_FLAG_CAPT 0
`define TMRB_STATUS_RUN 0
`define TMRB_DEBUG_RUN 0

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define TMRB_RST_READY 1'b1
`define TMRB_RESP_OKAY 1'b0
`define TMRB_FILT_DEPTH 4

`endif

// ---- verilog/tmrb_pkg.sv ----
// Types shared by the type B timer: modes, sequence states and carriers
package tmrb_pkg;

  // Operating modes; codes 6 and 7 are not served and hold the counter
  typedef enum logic [2:0] {
    TMRB_M_PERIODIC = 3'h0,
    TMRB_M_TIMEOUT = 3'h1,
    TMRB_M_CAPTURE = 3'h2,
    TMRB_M_FREQ = 3'h3,
    TMRB_M_PWIDTH = 3'h4,
    TMRB_M_FRQPW = 3'h5,
    TMRB_M_RSV6 = 3'h6,
    TMRB_M_RSV7 = 3'h7
  } tmrb_mode_t;

  // Edge sequence state, Gray coded along ARM-FIRST-SECOND-DONE
  typedef enum logic [1:0] {
    TMRB_S_ARM = 2'h0,
    TMRB_S_FIRST = 2'h1,
    TMRB_S_SECOND = 2'h3,
    TMRB_S_DONE = 2'h2
  } tmrb_seq_t;

  // Count rate choice
  typedef enum logic [1:0] {
    TMRB_CK_DIV1 = 2'h0,
    TMRB_CK_DIV2 = 2'h1,
    TMRB_CK_TYPEA = 2'h2,
    TMRB_CK_RSV = 2'h3
  } tmrb_clk_t;

  // Software settings
  typedef struct packed {
    logic enable;
    tmrb_clk_t prescale_select;
    logic stdby_run;
    tmrb_mode_t mode;
    logic edge_inv;
    logic filt_en;
    logic ev_en;
    logic inten;
    logic halt_override;
  } tmrb_cfg_t;

  // Bus data phase bookkeeping
  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] addr;
  } tmrb_dphase_t;

endpackage : tmrb_pkg

// ---- verilog/tmrb_top.sv ----
// Type B timer/counter with event capture modes and an AHB-Lite slave
`include "tmrb_params.svh"

// What this block does
// - Filter passes input after four equal samples
// - Filter adds four system-clock cycles latency
// - Reset selects periodic interrupt mode
// - Enable starts counting at selected rate
// - Periodic: count to compare, restart, flag
// - Top below count: wrap silently through max
// - Time-out: first edge restarts, second stops
// - Time-out: flag when count hits top
// - Frozen: edge restarts; reads, run writes inert
// - Capture: free count, copy on event, flag
// - Edge polarity selectable rising or falling
// - Reading capture high byte clears flag
// - Frequency: capture, restart, flag per edge
// - Pulse width: restart rise, capture fall
// - Pulse width alternates edges, two-cycle spacing
// - Combined: start rise, capture fall, stop rise
// - Combined: read or clear rearms sequence
// - Debug halt stops block unless overridden
// - Count from own prescaler or type A tick
// - Every flag set pulses event output
// - Interrupt while flag and enable set
// - Power-down halts; standby needs run setting
module tmrb_top
  import tmrb_pkg::*;
#(
  parameter int CNT_W = 16 // Count and capture width
) (
  input wire logic CLK_SYS, // System clock, 250 MHz
  input wire logic RST, // Asynchronous reset, active high
  input wire logic HSEL, // AHB-Lite slave select
  input wire logic [31:0] HADDR, // AHB-Lite address
  input wire logic [1:0] HTRANS, // AHB-Lite transfer type
  input wire logic HWRITE, // AHB-Lite direction
  input wire logic [2:0] HSIZE, // AHB-Lite size, words only
  input wire logic [31:0] HWDATA, // AHB-Lite write data
  input wire logic HREADY, // AHB-Lite bus ready
  output logic [31:0] HRDATA, // AHB-Lite read data
  output logic HREADYOUT, // AHB-Lite slave ready
  output logic HRESP, // AHB-Lite response, always OKAY
  input wire logic EVENT_IN, // Event input from routing network
  input wire logic TYPEA_TICK, // Prescaled tick of companion timer
  input wire logic DBG_HALT, // Processor halted for debug
  input wire logic SLEEP_STDBY, // Standby sleep active
  input wire logic SLEEP_PDOWN, // Power-down sleep active
  output logic IRQ, // Capture interrupt request
  output logic EVENT_OUT // One-cycle event strobe
);

  // --------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------
  // Bus words are 32 bits; a counter wider than that cannot be read
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("tmrb_top: CNT_W must lie between 2 and 32");
  end

  localparam int FD = `TMRB_FILT_DEPTH; // Filter sample depth

  // --------------------------------------------------------------------
  // State record
  // --------------------------------------------------------------------
  typedef struct packed {
    tmrb_cfg_t cfg; // Software settings
    logic [CNT_W-1:0] cnt; // Running count value
    logic [CNT_W-1:0] cmp; // Compare value / captured count
    tmrb_seq_t seq; // Edge sequence state
    logic flag; // Sticky capture flag
    logic div; // Divide-by-two phase
    logic [FD-1:0] hist; // Raw event samples, newest in bit 0
    logic filt; // Level fed to the edge detector
    logic prev; // Detector level one cycle ago
    tmrb_dphase_t dp; // Pending data phase
    logic [31:0] rdata; // Read data register
    logic irq; // Interrupt output register
    logic evout; // Event strobe register
    logic ready; // Slave ready register
    logic resp; // Slave response register
  } tmrb_state_t;

  tmrb_state_t s_q; // Registered state
  tmrb_state_t s_d; // Next state

  // --------------------------------------------------------------------
  // Gating and tick generation
  // --------------------------------------------------------------------
  logic halted; // Block suspended
  logic active; // Enabled and not suspended
  logic tick; // Count enable for this cycle
  logic stable; // All filter samples agree
  logic lvl; // Detector level after polarity
  logic plvl; // Previous level after polarity
  logic rise; // Selected edge seen
  logic fall; // Opposite edge seen
  logic take; // Address phase accepted
  logic run_now; // Counter is counting
  logic capt_mode; // A capture-type mode is active

  // Debug (unless overridden), power-down and standby (unless run set) suspend the block and mask its events
  assign halted = (DBG_HALT && !s_q.cfg.halt_override) ||
                  SLEEP_PDOWN ||
                  (SLEEP_STDBY && !s_q.cfg.stdby_run);
  assign active = s_q.cfg.enable && !halted;

  // Rate select; reserved code counts every cycle
  always_comb begin
    unique case (s_q.cfg.prescale_select)
      TMRB_CK_DIV1: tick = active;
      TMRB_CK_DIV2: tick = active && s_q.div;
      TMRB_CK_TYPEA: tick = active && TYPEA_TICK;
      TMRB_CK_RSV: tick = active;
    endcase
  end

  // --------------------------------------------------------------------
  // Noise filter and edge detector
  // --------------------------------------------------------------------
  // Four equal samples on the system clock, never on the prescaled tick
  assign stable = (&s_q.hist) || !(|s_q.hist);
  // Polarity choice folds into the level, so one detector serves all
  assign lvl = s_q.filt ^ s_q.cfg.edge_inv;
  assign plvl = s_q.prev ^ s_q.cfg.edge_inv;
  // Events are ignored while suspended or when input is disabled
  assign rise = lvl && !plvl && s_q.cfg.ev_en && active;
  assign fall = !lvl && plvl && s_q.cfg.ev_en && active;

  assign take = HSEL && HTRANS[1] && HREADY;

  // Read clears only apply to the capture-type modes
  assign capt_mode = (s_q.cfg.mode == TMRB_M_CAPTURE) ||
                     (s_q.cfg.mode == TMRB_M_FREQ) ||
                     (s_q.cfg.mode == TMRB_M_PWIDTH) ||
                     (s_q.cfg.mode == TMRB_M_FRQPW);

  // Run status: time-out freeze and idle combined phases read as stopped
  always_comb begin
    if (!s_q.cfg.enable) begin
      run_now = 1'b0;
    end else if (s_q.cfg.mode == TMRB_M_TIMEOUT) begin
      run_now = (s_q.seq != TMRB_S_DONE);
    end else if (s_q.cfg.mode == TMRB_M_FRQPW) begin
      run_now = (s_q.seq == TMRB_S_FIRST) ||
                (s_q.seq == TMRB_S_SECOND);
    end else begin
      run_now = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  logic set; // Flag set condition this cycle
  logic clr; // Flag clear request this cycle

  always_comb begin
    s_d = s_q;
    set = 1'b0;
    clr = 1'b0;
    s_d.ready = `TMRB_RST_READY; // Zero wait states
    s_d.resp = `TMRB_RESP_OKAY;

    // Filter samples and detector history
    s_d.div = ~s_q.div;
    s_d.hist = {s_q.hist[FD-2:0], EVENT_IN};
    if (!s_q.cfg.filt_en) begin
      s_d.filt = EVENT_IN; // Bypass: one register stage
    end else if (stable) begin
      s_d.filt = s_q.hist[0]; // Four more cycles behind
    end
    s_d.prev = s_q.filt;

    // Counter per mode
    if (!s_q.cfg.enable) begin
      s_d.seq = TMRB_S_ARM; // Disabled: sequences restart
    end else if (active) begin
      unique case (s_q.cfg.mode)
        TMRB_M_PERIODIC: begin
          // Match only on equality, so a lowered top wraps via max
          if (tick) begin
            if (s_q.cnt == s_q.cmp) begin
              s_d.cnt = '0;
              set = 1'b1;
            end else begin
              s_d.cnt = s_q.cnt + 1'b1;
            end
          end
        end
        TMRB_M_TIMEOUT: begin
          if (tick && s_q.seq != TMRB_S_DONE) begin
            s_d.cnt = s_q.cnt + 1'b1; // Wraps at max
            if (s_q.cnt == s_q.cmp) begin
              set = 1'b1;
            end
          end
          if (rise) begin
            unique case (s_q.seq)
              TMRB_S_ARM, TMRB_S_DONE: begin
                s_d.cnt = '0;
                s_d.seq = TMRB_S_FIRST;
              end
              TMRB_S_FIRST, TMRB_S_SECOND: begin
                s_d.seq = TMRB_S_DONE; // Freeze
              end
            endcase
          end
        end
        TMRB_M_CAPTURE: begin
          if (tick) begin
            s_d.cnt = s_q.cnt + 1'b1;
          end
          if (rise) begin
            s_d.cmp = s_q.cnt;
            set = 1'b1;
          end
        end
        TMRB_M_FREQ: begin
          if (tick) begin
            s_d.cnt = s_q.cnt + 1'b1;
          end
          if (rise) begin
            s_d.cmp = s_q.cnt;
            s_d.cnt = '0;
            set = 1'b1;
          end
        end
        TMRB_M_PWIDTH: begin
          if (tick) begin
            s_d.cnt = s_q.cnt + 1'b1;
          end
          // Detector alternates: wait for a rise, then for a fall
          if (s_q.seq != TMRB_S_FIRST && rise) begin
            s_d.cnt = '0;
            s_d.seq = TMRB_S_FIRST;
          end else if (s_q.seq == TMRB_S_FIRST && fall) begin
            s_d.cmp = s_q.cnt;
            set = 1'b1;
            s_d.seq = TMRB_S_ARM;
          end
        end
        TMRB_M_FRQPW: begin
          unique case (s_q.seq)
            TMRB_S_ARM: begin
              if (rise) begin
                s_d.cnt = '0;
                s_d.seq = TMRB_S_FIRST;
              end
            end
            TMRB_S_FIRST: begin
              if (tick) begin
                s_d.cnt = s_q.cnt + 1'b1;
              end
              if (fall) begin
                s_d.cmp = s_q.cnt;
                s_d.seq = TMRB_S_SECOND;
              end
            end
            TMRB_S_SECOND: begin
              if (tick) begin
                s_d.cnt = s_q.cnt + 1'b1;
              end
              if (rise) begin
                set = 1'b1; // Stop and flag
                s_d.seq = TMRB_S_DONE;
              end
            end
            TMRB_S_DONE: begin
              // Stays stopped until the flag is gone
              if (!s_q.flag) begin
                s_d.seq = TMRB_S_ARM;
              end
            end
          endcase
        end
        default: begin
          s_d.cnt = s_q.cnt; // Unserved mode codes hold
        end
      endcase
    end

    // Address phase: register read data, read side effects
    s_d.dp.valid = take;
    s_d.dp.write = HWRITE;
    s_d.dp.addr = HADDR[`TMRB_ADDR_W-1:0];
    if (take && !HWRITE) begin
      s_d.rdata = '0;
      unique case (HADDR[`TMRB_ADDR_W-1:0])
        `TMRB_OFS_CTRL: begin
          s_d.rdata[`TMRB_CTRL_ENABLE] = s_q.cfg.enable;
          s_d.rdata[`TMRB_CTRL_PRESCALE_SELECT_HI:`TMRB_CTRL_PRESCALE_SELECT_LO] =
            s_q.cfg.prescale_select;
          s_d.rdata[`TMRB_CTRL_STDBY] = s_q.cfg.stdby_run;
        end
        `TMRB_OFS_MODE: begin
          s_d.rdata[`TMRB_MODE_HI:`TMRB_MODE_LO] = s_q.cfg.mode;
          s_d.rdata[`TMRB_MODE_EDGE] = s_q.cfg.edge_inv;
          s_d.rdata[`TMRB_MODE_FILT] = s_q.cfg.filt_en;
          s_d.rdata[`TMRB_MODE_EVEN] = s_q.cfg.ev_en;
        end
        `TMRB_OFS_INTEN: s_d.rdata[`TMRB_INTEN_CAPT] = s_q.cfg.inten;
        `TMRB_OFS_FLAGS: s_d.rdata[`TMRB_FLAG_CAPT] = s_q.flag;
        `TMRB_OFS_STATUS: s_d.rdata[`TMRB_STATUS_RUN] = run_now;
        `TMRB_OFS_DEBUG: s_d.rdata[`TMRB_DEBUG_RUN] =
          s_q.cfg.halt_override;
        `TMRB_OFS_COUNT: s_d.rdata[CNT_W-1:0] = s_q.cnt;
        `TMRB_OFS_CMP: begin
          s_d.rdata[CNT_W-1:0] = s_q.cmp;
          // A word read always covers the high byte
          if (capt_mode) begin
            clr = 1'b1;
          end
        end
        default: s_d.rdata = '0; // Byte offsets inside a word read zero
      endcase
    end

    // Data phase writes take priority over counting
    if (s_q.dp.valid && s_q.dp.write) begin
      unique case (s_q.dp.addr)
        `TMRB_OFS_CTRL: begin
          s_d.cfg.enable = HWDATA[`TMRB_CTRL_ENABLE];
          s_d.cfg.prescale_select = tmrb_clk_t'(
            HWDATA[`TMRB_CTRL_PRESCALE_SELECT_HI:`TMRB_CTRL_PRESCALE_SELECT_LO]);
          s_d.cfg.stdby_run = HWDATA[`TMRB_CTRL_STDBY];
        end
        `TMRB_OFS_MODE: begin
          s_d.cfg.mode = tmrb_mode_t'(HWDATA[`TMRB_MODE_HI:`TMRB_MODE_LO]);
          s_d.cfg.edge_inv = HWDATA[`TMRB_MODE_EDGE];
          s_d.cfg.filt_en = HWDATA[`TMRB_MODE_FILT];
          s_d.cfg.ev_en = HWDATA[`TMRB_MODE_EVEN];
          // A new mode starts its edge sequence afresh
          if (s_d.cfg.mode != s_q.cfg.mode) begin
            s_d.seq = TMRB_S_ARM;
          end
        end
        `TMRB_OFS_INTEN: s_d.cfg.inten = HWDATA[`TMRB_INTEN_CAPT];
        `TMRB_OFS_FLAGS: clr = clr || HWDATA[`TMRB_FLAG_CAPT];
        `TMRB_OFS_DEBUG: s_d.cfg.halt_override = HWDATA[`TMRB_DEBUG_RUN];
        `TMRB_OFS_COUNT: s_d.cnt = HWDATA[CNT_W-1:0];
        `TMRB_OFS_CMP: s_d.cmp = HWDATA[CNT_W-1:0];
        default: s_d.cfg = s_d.cfg; // Status is read-only
      endcase
    end

    // Flag: a set in the clearing cycle wins
    s_d.flag = set || (s_q.flag && !clr);
    s_d.evout = set;
    s_d.irq = s_d.flag && s_d.cfg.inten;
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  // Reset zeroes all but ready: periodic mode, disabled, flag clear
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      s_q <= '0;
      s_q.ready <= `TMRB_RST_READY;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------
  // Outputs, each straight from the state register
  // --------------------------------------------------------------------
  assign HRDATA = s_q.rdata;
  assign HREADYOUT = s_q.ready;
  assign HRESP = s_q.resp;
  assign IRQ = s_q.irq;
  assign EVENT_OUT = s_q.evout;

endmodule // tmrb_top

// ---- verification/tmrb_checker.sv ----
// Port-level assertions for the type B timer
`include "tmrb_params.svh"
module tmrb_checker
  import tmrb_pkg::*;
#(
  parameter int CNT_W = 16 // Count width, unused by the checks
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic DBG_HALT,
  input wire logic SLEEP_PDOWN,
  input wire logic IRQ,
  input wire logic EVENT_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Shadow of the settings that gate events
  // ------------------------------------------------------------
  logic req; // Transfer taken this edge
  logic wr_q; // Data phase of a write pending
  logic [4:0] adr_q; // Address of that data phase
  logic ov_q; // Shadow of halt_override
  logic ien_q; // Shadow of interrupt enable
  assign req = HSEL & HTRANS[1] & HREADY;
  // Follows writes so the gating checks know the live settings
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wr_q <= 1'h0;
      adr_q <= 5'h00;
      ov_q <= 1'h0;
      ien_q <= 1'h0;
    end else begin
      if (HREADY) begin
        wr_q <= req & HWRITE;
        adr_q <= HADDR[4:0];
      end
      // Aligned offsets only, unaligned writes do nothing
      if (wr_q && adr_q == `TMRB_OFS_DEBUG) ov_q <= HWDATA[0];
      if (wr_q && adr_q == `TMRB_OFS_INTEN) ien_q <= HWDATA[0];
    end
  end
  // ------------------------------------------------------------
  // Assertions, one clock domain
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  a_ready_high: assert property (HREADYOUT)
    else $error("slave ready low");
  a_resp_okay: assert property (!HRESP)
    else $error("slave response not okay");
  a_rdata_hold: assert property (!$past(req && !HWRITE) |-> $stable(HRDATA))
    else $error("read data moved without a read");
  a_evout_single: assert property (EVENT_OUT |=> !EVENT_OUT)
    else $error("event strobe longer than one cycle");
  // Enable and interrupt register update at the same edge
  a_irq_needs_en: assert property (IRQ |-> ien_q)
    else $error("interrupt without enable");
  a_irq_on_flag: assert property (
    EVENT_OUT && $past(ien_q) && ien_q |-> IRQ)
    else $error("flag set but no interrupt");
  a_irq_fall_cause: assert property ($fell(IRQ) |->
    $past(req) || $past(req, 2) || $past(req, 3))
    else $error("interrupt dropped without software");
  a_halt_quiet: assert property (
    $past(DBG_HALT && !ov_q) |-> !EVENT_OUT)
    else $error("event while halted for debug");
  a_pdown_quiet: assert property (
    $past(SLEEP_PDOWN) |-> !EVENT_OUT)
    else $error("event in power-down");
endmodule // tmrb_checker

// ---- verification/tmrb_evsrc.sv ----
// Event routing source model driving the timer's event input
module tmrb_evsrc (
  input wire logic clk, // System clock
  output logic ev // Event level, idles low
);
  timeunit 1ns;
  timeprecision 100ps;
  initial ev = 1'h0;
  // One pulse; each level held two cycles or more
  task automatic pulse(input int hi, input int lo);
    int h;
    int l;
    h = (hi < 2) ? 2 : hi;
    l = (lo < 2) ? 2 : lo;
    @(posedge clk);
    ev <= 1'h1;
    repeat (h) @(posedge clk);
    ev <= 1'h0;
    repeat (l - 1) @(posedge clk);
  endtask
endmodule // tmrb_evsrc

// ---- verification/testbench.sv ----
// Self-checking bench for the type B timer
`include "tmrb_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Signals and register offsets
  // ------------------------------------------------------------
  localparam logic [4:0] o_ctl = `TMRB_OFS_CTRL;
  localparam logic [4:0] o_mod = `TMRB_OFS_MODE;
  localparam logic [4:0] o_flg = `TMRB_OFS_FLAGS;
  localparam logic [4:0] o_sta = `TMRB_OFS_STATUS;
  localparam logic [4:0] o_cnt = `TMRB_OFS_COUNT;
  localparam logic [4:0] o_cmp = `TMRB_OFS_CMP;
  logic clk, rst, hsel, hwrite, ta_tick, dbg, pdown, stb, ev;
  logic hreadyout, hresp, irq, ev_out;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r, a, b, d;
  int bad_count, checked, i;
  int evn = 0; // Event strobes seen on the output
  tmrb_top uut (.CLK_SYS(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .EVENT_IN(ev), .TYPEA_TICK(ta_tick), .DBG_HALT(dbg),
    .SLEEP_STDBY(stb), .SLEEP_PDOWN(pdown), .IRQ(irq), .EVENT_OUT(ev_out));
  tmrb_evsrc evs (.clk(clk), .ev(ev));
  // Counts strobes, sampled as settled before the edge updates them
  always @(posedge clk) if (ev_out === 1'h1) evn <= evn + 1;
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Tasks: bus, compares, close
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic e);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  // Bounded wait for the slave's ready
  task automatic wt;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'h1 && n < 64);
    if (hreadyout !== 1'h1) begin
      bad_count++;
      end_of_test;
    end
  endtask
  // One AHB-Lite single transfer; read data lands in r
  task automatic bus(input logic w, input logic [4:0] ad,
    input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {27'h0, ad};
    wt;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wt;
    r = hrdata;
  endtask
  // Count advance across twelve cycles; reads count first
  task automatic delta(output logic [31:0] dd);
    logic [31:0] s;
    bus(1'h0, o_cnt, 32'h0);
    s = r;
    repeat (9) @(posedge clk);
    bus(1'h0, o_cnt, 32'h0);
    dd = (r - s) & 32'h0000FFFF;
  endtask
  // Seen-high test of the interrupt over n cycles
  task automatic wait_irq(input int n, input logic e);
    logic s;
    s = 1'h0;
    repeat (n) begin
      @(posedge clk);
      if (irq === 1'h1) s = 1'h1;
    end
    chk({31'h0, s}, {31'h0, e});
  endtask
  // Zeroed count, one pulse, captured value and flag clear by read
  task automatic cap(input int h, input logic [31:0] e);
    int e0;
    bus(1'h1, o_flg, 32'h1);
    bus(1'h1, o_cnt, 32'h0);
    e0 = evn;
    evs.pulse(h, 8);
    chk_irq(1'h1);
    chk(evn - e0, 32'h1);
    bus(1'h0, o_cmp, 32'h0);
    chk(r, e);
    repeat (2) @(posedge clk);
    chk_irq(1'h0);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {hsel, hwrite, ta_tick, dbg, pdown, stb} = 6'h00;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    bad_count = 0;
    checked = 0;
    rst = 1'h1;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    // Reset values, read-only status, unaligned place
    for (i = 0; i < 8; i++) begin
      bus(1'h0, 5'(i * 4), 32'h0);
      chk(r, 32'h0);
    end
    bus(1'h1, o_sta, 32'h1);
    bus(1'h0, o_sta, 32'h0);
    chk(r, 32'h0);
    bus(1'h1, 5'h1E, 32'hFF);
    bus(1'h0, 5'h1E, 32'h0);
    chk(r, 32'h0);
    // Count rates: every clock, every second, type A tick
    bus(1'h1, o_cmp, 32'hFFFF);
    bus(1'h1, o_ctl, 32'h1);
    delta(d);
    chk(d, 32'hC);
    bus(1'h1, o_sta, 32'h0);
    bus(1'h0, o_sta, 32'h0);
    chk(r, 32'h1);
    bus(1'h1, o_ctl, 32'h3);
    delta(d);
    chk(d, 32'h6);
    bus(1'h1, o_ctl, 32'h5);
    delta(d);
    chk(d, 32'h0);
    ta_tick <= 1'h1;
    delta(d);
    chk(d, 32'hC);
    ta_tick <= 1'h0;
    // Periodic: hit top, then top below count wraps silently
    bus(1'h1, o_ctl, 32'h0);
    bus(1'h1, o_cmp, 32'h8);
    bus(1'h1, o_cnt, 32'h0);
    bus(1'h1, `TMRB_OFS_INTEN, 32'h1);
    bus(1'h1, o_ctl, 32'h1);
    wait_irq(20, 1'h1);
    bus(1'h1, o_ctl, 32'h0);
    bus(1'h1, o_flg, 32'h1);
    bus(1'h1, o_cnt, 32'hFFF0);
    bus(1'h1, o_ctl, 32'h1);
    wait_irq(13, 1'h0);
    wait_irq(20, 1'h1);
    // Capture: rising, falling, noise filter
    bus(1'h1, o_mod, 32'h42);
    cap(5, 32'h2);
    bus(1'h1, o_mod, 32'h52);
    cap(5, 32'h7);
    bus(1'h1, o_mod, 32'h62);
    bus(1'h1, o_flg, 32'h1);
    evs.pulse(2, 8);
    wait_irq(4, 1'h0);
    cap(5, 32'h6);
    // Frequency: periods nine and twelve
    bus(1'h1, o_mod, 32'h43);
    evs.pulse(3, 6);
    evs.pulse(3, 4);
    bus(1'h0, o_cmp, 32'h0);
    a = r;
    chk_irq(1'h0);
    evs.pulse(3, 9);
    evs.pulse(3, 4);
    bus(1'h0, o_cmp, 32'h0);
    chk(r - a, 32'h3);
    chk(a >> 4, 32'h0);
    // Pulse width: highs of three and six
    bus(1'h1, o_mod, 32'h44);
    evs.pulse(3, 4);
    bus(1'h0, o_cmp, 32'h0);
    a = r;
    evs.pulse(6, 4);
    bus(1'h0, o_cmp, 32'h0);
    b = r;
    chk(b - a, 32'h3);
    chk_irq(1'h0);
    // Combined: flag only at second rise, then stopped, then rearm
    bus(1'h1, o_mod, 32'h45);
    bus(1'h1, o_flg, 32'h1);
    evs.pulse(3, 4);
    chk_irq(1'h0);
    evs.pulse(3, 4);
    chk_irq(1'h1);
    bus(1'h0, o_sta, 32'h0);
    chk(r, 32'h0);
    delta(d);
    chk(d, 32'h0);
    bus(1'h0, o_cmp, 32'h0);
    chk(r, a);
    evs.pulse(6, 4);
    evs.pulse(3, 4);
    bus(1'h0, o_cmp, 32'h0);
    chk(r, b);
    // Time-out: restart, freeze, inert access, restart, expiry
    bus(1'h1, o_mod, 32'h41);
    bus(1'h1, o_cmp, 32'h1E);
    bus(1'h1, o_cnt, 32'h0);
    bus(1'h1, o_flg, 32'h1);
    evs.pulse(3, 3);
    evs.pulse(3, 3);
    bus(1'h0, o_cnt, 32'h0);
    bus(1'h1, o_sta, 32'h1);
    bus(1'h0, o_sta, 32'h0);
    chk(r, 32'h0);
    wait_irq(40, 1'h0);
    evs.pulse(3, 3);
    bus(1'h0, o_sta, 32'h0);
    chk(r, 32'h1);
    wait_irq(40, 1'h1);
    // Debug halt with and without override, power-down
    bus(1'h1, o_mod, 32'h42);
    dbg <= 1'h1;
    bus(1'h1, o_flg, 32'h1);
    evs.pulse(3, 6);
    wait_irq(4, 1'h0);
    bus(1'h1, `TMRB_OFS_DEBUG, 32'h1);
    evs.pulse(3, 6);
    wait_irq(4, 1'h1);
    dbg <= 1'h0;
    bus(1'h1, o_flg, 32'h1);
    pdown <= 1'h1;
    evs.pulse(3, 6);
    wait_irq(4, 1'h0);
    pdown <= 1'h0;
    stb <= 1'h1;
    evs.pulse(3, 6);
    wait_irq(4, 1'h0);
    bus(1'h1, o_ctl, 32'h41);
    evs.pulse(3, 6);
    wait_irq(4, 1'h1);
    stb <= 1'h0;
    end_of_test;
  end
endmodule // testbench
bind tmrb_top tmrb_checker #(.CNT_W(CNT_W)) chk_i (.CLK_SYS(CLK_SYS),
  .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DBG_HALT(DBG_HALT),
  .SLEEP_PDOWN(SLEEP_PDOWN), .IRQ(IRQ), .EVENT_OUT(EVENT_OUT));
